/* File: pkg/sec_pkg.sv */
package sec_pkg;
  // ------------------------------------------------------------------
  // command codes and mode fields
  // ------------------------------------------------------------------
  localparam logic [7:0] OP_RANDOM = 8'h1B;
  localparam logic [7:0] OP_READ = 8'h02;
  localparam logic [7:0] OP_CHECK = 8'h0E;
  localparam logic [7:0] OP_HASH = 8'h47;
  localparam logic [7:0] HASH_START = 8'h00;
  localparam logic [7:0] HASH_UPDATE = 8'h01;
  localparam logic [7:0] HASH_FIN_KEY = 8'h02;
  localparam logic [7:0] HASH_FIN_MDB = 8'h42;
  localparam logic [7:0] HASH_FIN_OUT = 8'hC2;
  localparam int READ_LEN_BIT = 7;
  localparam logic [7:0] CHECK_LEGAL = 8'h3D;
  localparam logic [1:0] ZONE_CFG = 2'h0;
  localparam logic [1:0] ZONE_OTP = 2'h1;
  localparam logic [1:0] ZONE_DATA = 2'h2;
  localparam logic [15:0] CLEAR_SLOTS = 16'h1D20;
  localparam int SLOT_LSB = 3;
  // ------------------------------------------------------------------
  // answer codes and lengths
  // ------------------------------------------------------------------
  localparam logic [7:0] ST_OK = 8'h00;
  localparam logic [7:0] ERR_PARSE = 8'h03;
  localparam logic [7:0] ERR_DENIED = 8'h0F;
  localparam logic [7:0] ERR_ENGINE_CHECK_COMMAND = 8'h07;
  localparam logic [7:0] ERR_HEALTH = 8'h08;
  localparam logic [6:0] LEN_SHORT = 7'd4;
  localparam logic [6:0] LEN_LONG = 7'd32;
  localparam logic [6:0] LEN_STATUS = 7'd1;
  localparam logic [6:0] CHUNK_MAX = 7'd64;
  localparam logic [5:0] FAIL_RESET = 6'h00;
  // ------------------------------------------------------------------
  // carriers and states
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] mode;
    logic [15:0] second_parameter;
  } sec_cmd_s;
  typedef struct packed {
    logic [7:0] data;
    logic last;
  } sec_resp_s;
  typedef enum logic [1:0] {
    SRC_STAT = 2'h0, SRC_RNG = 2'h1, SRC_MEM = 2'h2, SRC_DIG = 2'h3
  } sec_src_e;
  typedef enum logic [5:0] {
    S_IDLE = 6'b000001, S_EXEC = 6'b000010, S_DATA = 6'b000100,
    S_TEST = 6'b001000, S_FIN = 6'b010000, S_SEND = 6'b100000
  } sec_state_e;
endpackage

/* File: src/sec_cmd_exec.sv */
`timescale 1ns/1ps
// How it works
// - random command answers 32 fresh generator bytes
// - random bytes flow straight to the answer, never stored
// - read mode bit 7 picks 32 or 4 bytes, low bits pick zone
// - configuration zone always readable in clear, one-time zone only while no failure is latched
// - data zone clear reads only for slots 5, 8, 10 to 12
// - read answers 4 or 32 bytes, byte 0 first
// - encrypted reads never offered on configuration or one-time zones
// - engine check runs only on host command, never at start
// - any failed check latches failure state; wake or power clears it
// - commands refused after a check failure report 0x07, distinct from health failure 0x08
// - in failure only config reads and checks run; rest gives 0x07
// - passing rerun clears its failure bit; all clear resumes service
// - check with mode 0 runs nothing, returns failure register
// - check mode bits select hash, cipher, agreement, signature, random
// - check answers one byte: zero, or map of failed tests
// - hash context private, other commands may interleave freely
// - hash context invalidated on power-up and wake
// - hash command errors leave the context unchanged
// - update carries 1 to 64 bytes, count in low parameter byte
// - finalize takes 0 to 64 bytes, copies digest per mode
// - start and update answer one status byte, finalize 32 bytes
module sec_cmd_exec import sec_pkg::*; (
  input wire logic sys_clk,          // core clock, 50 MHz
  input wire logic reset,            // synchronous, power-up
  input wire logic ce,               // clock enable, freezes core
  input wire logic wake,             // wake event pulse
  input wire logic cmd_valid,        // command offered
  output logic cmd_ready,            // command taken
  input wire sec_cmd_s cmd,          // opcode, mode, parameter
  input wire logic data_valid,       // message byte offered
  output logic data_ready,           // message byte taken
  input wire logic [7:0] data_byte,  // message byte
  input wire logic rng_valid,        // generator byte ready
  output logic rng_ready,            // generator byte taken
  input wire logic [7:0] rng_byte,   // generator byte
  output logic [1:0] mem_zone,       // zone to read
  output logic [15:0] mem_addr,      // read address
  output logic [4:0] mem_index,      // byte within read
  input wire logic [7:0] mem_rdata,  // combinational read data
  output logic st_start,             // engine check start pulse
  output logic [5:0] st_sel,         // tests to run
  input wire logic st_done,          // checks finished pulse
  input wire logic [5:0] st_fail,    // failed tests map
  output logic eng_init,             // hash engine restart pulse
  output logic eng_byte_valid,       // byte into hash engine
  output logic [7:0] eng_byte,       // hash engine byte
  input wire logic eng_ready,        // hash engine accepts byte
  output logic eng_final,            // finish digest pulse
  input wire logic eng_done,         // digest ready pulse
  input wire logic [255:0] eng_digest, // digest, byte 0 in msbs
  output logic key_load,             // temporary key register load
  output logic mdb_load,             // digest buffer load
  output logic [255:0] copy_digest,  // digest for the copies
  output logic [5:0] fail_state,     // failure register
  output logic hash_valid,           // hash context valid
  input wire logic link_clk,         // response link clock
  input wire logic resp_ready,       // host takes byte
  output logic resp_valid,           // byte on the link
  output sec_resp_s resp             // byte and last flag
);
  // ------------------------------------------------------------------
  // decoding helpers
  // ------------------------------------------------------------------
  function automatic logic slot_ok(input logic [15:0] addr);
    slot_ok = CLEAR_SLOTS[addr[SLOT_LSB +: 4]];
  endfunction

  sec_state_e state;
  sec_cmd_s cur;
  sec_src_e src;
  logic [6:0] count;
  logic [6:0] len;
  logic [7:0] stat;
  logic [5:0] fail_reg;
  logic ctx_valid;
  logic fin_pend;
  logic tx_req;
  logic [7:0] tx_byte;
  logic tx_last;
  logic ack_s1;
  logic ack_s2;
  logic lk_rst_s1;
  logic lk_rst;
  logic lk_req_s1;
  logic lk_req_s2;
  logic lk_ack;

  // ------------------------------------------------------------------
  // command classification
  // ------------------------------------------------------------------
  wire is_rand = cur.opcode == OP_RANDOM;
  wire rand_ok = cur.mode == 8'h00 && cur.second_parameter == 16'h0000;
  wire is_read = cur.opcode == OP_READ;
  wire [1:0] zone = cur.mode[1:0];
  wire read_form = cur.mode[6:2] == 5'h00 && zone != 2'h3;
  wire [6:0] read_len = cur.mode[READ_LEN_BIT] ? LEN_LONG : LEN_SHORT;
  // configuration and one-time zones skip the slot policy check
  wire read_allow = zone != ZONE_DATA
    || slot_ok(cur.second_parameter);
  wire is_check = cur.opcode == OP_CHECK;
  wire check_form = (cur.mode & ~CHECK_LEGAL) == 8'h00;
  wire is_hash = cur.opcode == OP_HASH;
  wire [6:0] chunk_length = cur.second_parameter[6:0];
  wire chunk_hi_ok = cur.second_parameter[15:7] == 9'h000;
  wire chunk_ok = chunk_hi_ok && chunk_length <= CHUNK_MAX;
  wire is_fin = cur.mode == HASH_FIN_KEY || cur.mode == HASH_FIN_MDB
    || cur.mode == HASH_FIN_OUT;
  // while failed only config reads and checks pass the gate
  wire allowed = fail_reg == 6'h00 || is_check
    || (is_read && zone == ZONE_CFG);
  wire busy = tx_req != ack_s2;
  wire [7:0] dig_bytes [32];
  wire [7:0] src_byte;
  wire src_ok = src != SRC_RNG || rng_valid;
  wire send_go = state == S_SEND && !busy && count != len && src_ok;
  wire data_go = state == S_DATA && data_valid && eng_ready && count != len;

  // digest byte 0 leaves first, from the top of the digest word
  for (genvar i = 0; i < 32; i++) begin : g_dig
    assign dig_bytes[i] = copy_digest[255 - 8 * i -: 8];
  end

  // answer byte source selection
  assign src_byte = src == SRC_RNG ? rng_byte
    : src == SRC_MEM ? mem_rdata
    : src == SRC_DIG ? dig_bytes[count[4:0]] : stat;
  assign cmd_ready = state == S_IDLE;
  assign data_ready = data_go;
  assign eng_byte_valid = data_go;
  assign eng_byte = data_byte;
  // generator bytes are pulled on send_go, which ignores ce, so a core held by ce low still pulls them unsent
  assign rng_ready = send_go && src == SRC_RNG;
  assign mem_zone = zone;
  assign mem_addr = cur.second_parameter;
  assign mem_index = count[4:0];
  assign fail_state = fail_reg;
  assign hash_valid = ctx_valid;

  // ------------------------------------------------------------------
  // command sequencer
  // ------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state <= S_IDLE;
      cur <= '0;
      src <= SRC_STAT;
      count <= 7'd0;
      len <= 7'd0;
      stat <= ST_OK;
      ctx_valid <= 1'b0;
      fin_pend <= 1'b0;
      st_start <= 1'b0;
      st_sel <= 6'h00;
      eng_init <= 1'b0;
      eng_final <= 1'b0;
      key_load <= 1'b0;
      mdb_load <= 1'b0;
      copy_digest <= '0;
    end else if (ce) begin
      st_start <= 1'b0;
      eng_init <= 1'b0;
      eng_final <= 1'b0;
      key_load <= 1'b0;
      mdb_load <= 1'b0;
      if (wake) begin
        ctx_valid <= 1'b0;
      end
      unique case (state)
        S_IDLE: begin
          if (cmd_valid) begin
            cur <= cmd;
            state <= S_EXEC;
          end
        end
        S_EXEC: begin
          count <= 7'd0;
          len <= LEN_STATUS;
          src <= SRC_STAT;
          stat <= ERR_PARSE;
          state <= S_SEND;
          if (!allowed) begin
            stat <= ERR_ENGINE_CHECK_COMMAND;
          end else if (is_rand && rand_ok) begin
            src <= SRC_RNG;
            len <= LEN_LONG;
          end else if (is_read && read_form) begin
            if (read_allow) begin
              src <= SRC_MEM;
              len <= read_len;
            end else begin
              stat <= ERR_DENIED;
            end
          end else if (is_check && check_form
              && cur.second_parameter == 16'h0000) begin
            if (cur.mode == 8'h00) begin
              stat <= {2'b00, fail_reg};
            end else begin
              st_sel <= cur.mode[5:0];
              st_start <= 1'b1;
              state <= S_TEST;
            end
          end else if (is_hash && cur.mode == HASH_START
              && cur.second_parameter == 16'h0000) begin
            ctx_valid <= 1'b1;
            eng_init <= 1'b1;
            stat <= ST_OK;
          end else if (is_hash && ctx_valid && chunk_ok
              && (cur.mode == HASH_UPDATE && chunk_length != 7'd0
              || is_fin)) begin
            // bad counts fall to the parse error with context intact
            len <= chunk_length;
            fin_pend <= is_fin;
            state <= S_DATA;
          end
        end
        S_DATA: begin
          if (data_go) begin
            count <= count + 7'd1;
          end else if (count == len) begin
            count <= 7'd0;
            if (fin_pend) begin
              eng_final <= 1'b1;
              state <= S_FIN;
            end else begin
              len <= LEN_STATUS;
              stat <= ST_OK;
              state <= S_SEND;
            end
          end
        end
        S_TEST: begin
          if (st_done) begin
            stat <= {2'b00, st_fail & st_sel};
            state <= S_SEND;
          end
        end
        S_FIN: begin
          if (eng_done) begin
            copy_digest <= eng_digest;
            key_load <= cur.mode == HASH_FIN_KEY;
            mdb_load <= cur.mode == HASH_FIN_MDB;
            ctx_valid <= wake ? 1'b0 : 1'b0;
            src <= SRC_DIG;
            len <= LEN_LONG;
            state <= S_SEND;
          end
        end
        S_SEND: begin
          if (send_go) begin
            count <= count + 7'd1;
          end else if (count == len && !busy) begin
            state <= S_IDLE;
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // failure register
  // ------------------------------------------------------------------
  // a check result landing with wake still records its failures
  wire [5:0] next_fail = st_done && state == S_TEST
    ? ((wake ? 6'h00 : fail_reg) & ~st_sel) | (st_fail & st_sel)
    : (wake ? 6'h00 : fail_reg);

  // passing reruns drop their bit, failures latch
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      fail_reg <= FAIL_RESET;
    end else if (ce) begin
      fail_reg <= next_fail;
    end
  end

  // ------------------------------------------------------------------
  // byte hand-off toward the link clock
  // ------------------------------------------------------------------
  // toggle handshake: byte is held stable until the link side acks
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      tx_req <= 1'b0;
      tx_byte <= 8'h00;
      tx_last <= 1'b0;
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
    end else if (ce) begin
      ack_s1 <= lk_ack;
      ack_s2 <= ack_s1;
      if (send_go) begin
        tx_byte <= src_byte;
        tx_last <= count + 7'd1 == len;
        tx_req <= ~tx_req;
      end
    end
  end

  // ------------------------------------------------------------------
  // link side
  // ------------------------------------------------------------------
  // reset reaches the link domain through its own synchroniser
  always_ff @(posedge link_clk) begin
    lk_rst_s1 <= reset;
    lk_rst <= lk_rst_s1;
  end

  // one holding stage; ack returns once the byte is captured
  always_ff @(posedge link_clk) begin
    if (lk_rst) begin
      lk_req_s1 <= 1'b0;
      lk_req_s2 <= 1'b0;
      lk_ack <= 1'b0;
      resp_valid <= 1'b0;
      resp <= '0;
    end else begin
      lk_req_s1 <= tx_req;
      lk_req_s2 <= lk_req_s1;
      if (resp_valid && resp_ready) begin
        resp_valid <= 1'b0;
      end else if (!resp_valid && lk_req_s2 != lk_ack) begin
        resp <= '{data: tx_byte, last: tx_last};
        resp_valid <= 1'b1;
        lk_ack <= lk_req_s2;
      end
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  chk_rand_len: assert property (state == S_EXEC && ce && allowed
    && is_rand && rand_ok |=> len == LEN_LONG && src == SRC_RNG)
    else $error("random answer not 32 generator bytes");
  chk_read_len: assert property (state == S_EXEC && ce && allowed
    && is_read && read_form && read_allow |=> len == read_len)
    else $error("read length does not follow mode bit");
  chk_slot_deny: assert property (state == S_EXEC && ce && allowed
    && is_read && read_form && zone == ZONE_DATA
    && !CLEAR_SLOTS[cur.second_parameter[6:3]]
    |=> stat == ERR_DENIED && src == SRC_STAT)
    else $error("closed slot read not refused");
  chk_fail_gate: assert property (state == S_EXEC && ce
    && fail_reg != 6'h00 && !is_check && !(is_read && zone == ZONE_CFG)
    |=> stat == ERR_ENGINE_CHECK_COMMAND && state == S_SEND)
    else $error("command passed while failed");
  chk_fail_map: assert property (state == S_TEST && st_done && ce
    && !wake |=> fail_reg == (($past(fail_reg) & ~$past(st_sel))
    | ($past(st_fail) & $past(st_sel))))
    else $error("failure register update wrong");
  chk_wake_clear: assert property (wake && ce && state != S_TEST
    |=> fail_reg == 6'h00 && !ctx_valid)
    else $error("wake did not clear state");
  chk_no_autotest: assert property (st_start |->
    $past(state) == S_EXEC && $past(is_check))
    else $error("check started without command");
  chk_ctx_keep: assert property (state == S_EXEC && ce && is_hash
    && cur.mode == HASH_UPDATE && !chunk_ok |=> ctx_valid == $past(ctx_valid)
    && stat == ERR_PARSE)
    else $error("hash error touched context");
  chk_fin_copy: assert property (state == S_FIN && eng_done && ce
    |=> key_load == (cur.mode == HASH_FIN_KEY) && len == LEN_LONG
    && mdb_load == (cur.mode == HASH_FIN_MDB))
    else $error("digest copy mismatch");
  chk_rng_pull: assert property (rng_ready |-> state == S_SEND
    && src == SRC_RNG && !busy)
    else $error("generator read outside answer");

  cov_rand: cover property (state == S_EXEC && is_rand && rand_ok);
  cov_fail: cover property (fail_reg != 6'h00 ##1 fail_reg == 6'h00);
  cov_fin: cover property (state == S_FIN && eng_done);
  cov_deny: cover property (state == S_SEND && stat == ERR_DENIED);
endmodule

/* File: verification/sec_periph_model.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------------
// stand-ins for generator, memory, check engines and hash core
// ------------------------------------------------------------------
module sec_periph_model import sec_pkg::*; (
  input wire logic sys_clk,          // core clock
  input wire logic rng_ready,        // generator byte taken
  output logic rng_valid,            // generator byte ready
  output logic [7:0] rng_byte,       // generator byte
  input wire logic [1:0] mem_zone,   // zone read
  input wire logic [4:0] mem_index,  // byte within read
  output logic [7:0] mem_rdata,      // read data
  input wire logic st_start,         // check start pulse
  input wire logic [5:0] st_sel,     // tests to run
  input wire logic [5:0] fail_mask,  // tests told to fail
  output logic st_done,              // checks finished pulse
  output logic [5:0] st_fail,        // failed map
  input wire logic eng_init,         // hash restart
  input wire logic eng_byte_valid,   // hash byte offered
  input wire logic [7:0] eng_byte,   // hash byte
  output logic eng_ready,            // hash byte taken
  input wire logic eng_final,        // finish pulse
  output logic eng_done,             // digest ready pulse
  output logic [255:0] eng_digest,   // digest, byte 0 in msbs
  input wire logic key_load,         // key copy pulse
  input wire logic mdb_load,         // buffer copy pulse
  output int n_start,                // check starts seen
  output int n_key,                  // key copies seen
  output int n_mdb                   // buffer copies seen
);
  logic [7:0] sum = 8'h00;
  logic [7:0] rng_cnt = 8'h00;
  logic slow = 1'b0;
  int st_wait = 0;
  int eng_wait = 0;
  // readiness wanders so the block meets prompt and slow partners
  assign rng_valid = slow;
  assign eng_ready = ~slow;
  assign rng_byte = rng_cnt;
  // memory byte tells its zone and index, so order errors show
  assign mem_rdata = {mem_zone, 1'b0, mem_index};
  // toy digest: running byte sum plus position, cheap to predict
  always_comb begin
    for (int k = 0; k < 32; k++) begin
      eng_digest[255-8*k -: 8] = sum + 8'(k);
    end
  end
  // engines answer after fixed delays; === keeps pre-reset x out
  always @(posedge sys_clk) begin
    slow <= ($urandom % 3) == 0;
    st_done <= st_wait == 1;
    eng_done <= eng_wait == 1;
    st_fail <= fail_mask & st_sel;
    if (st_wait > 0) st_wait <= st_wait - 1;
    if (eng_wait > 0) eng_wait <= eng_wait - 1;
    if (st_start === 1'b1) begin
      st_wait <= 4;
      n_start <= n_start + 1;
    end
    if (eng_final === 1'b1) eng_wait <= 6;
    if (rng_valid && rng_ready === 1'b1) rng_cnt <= rng_cnt + 8'h01;
    if (eng_init === 1'b1) sum <= 8'h00;
    else if (eng_byte_valid === 1'b1 && eng_ready) sum <= sum + eng_byte;
    if (key_load === 1'b1) n_key <= n_key + 1;
    if (mdb_load === 1'b1) n_mdb <= n_mdb + 1;
  end
  initial begin
    n_start = 0;
    n_key = 0;
    n_mdb = 0;
  end
endmodule

/* File: verification/secure_element_cmd_exec_bench.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin num_errors++; \
  $display("wrong value at %0t: got %0h want %0h", $time, g, e); end end
module secure_element_cmd_exec_bench import sec_pkg::*; ;
  logic sys_clk = 0;
  logic link_clk = 0;
  logic reset = 1;
  logic wake = 0;
  logic cmd_valid = 0;
  logic data_valid = 0;
  logic resp_ready = 0;
  logic done = 0;
  sec_cmd_s cmd = '0;
  logic [7:0] data_byte = 8'h00;
  logic [5:0] fail_mask = 6'h00;
  logic cmd_ready, data_ready, rng_valid, rng_ready, st_start, st_done;
  logic eng_init, eng_byte_valid, eng_ready, eng_final, eng_done;
  logic key_load, mdb_load, hash_valid, resp_valid;
  logic [7:0] rng_byte, mem_rdata, eng_byte, hs;
  logic [1:0] mem_zone;
  logic [4:0] mem_index;
  logic [5:0] st_sel, st_fail, fail_state;
  logic [255:0] eng_digest;
  logic [255:0] copy_digest;
  logic [15:0] mem_addr;
  bit rdy = 0;
  sec_resp_s resp;
  logic [7:0] rq[$];
  logic [7:0] eq[$];
  logic [7:0] fm[3] = '{HASH_FIN_KEY, HASH_FIN_MDB, HASH_FIN_OUT};
  int num_errors = 0;
  int checks = 0;
  int rn = 0;
  int n_start, n_key, n_mdb, k0, m0, c;
  int ok_slot[5] = '{5, 8, 10, 11, 12};
  // ----------------------------------------------------------------
  // clocks, design and surroundings
  // ----------------------------------------------------------------
  initial forever #10 sys_clk = ~sys_clk;
  initial begin
    #7;
    forever #40 link_clk = ~link_clk;
  end
  sec_cmd_exec dut_u (.sys_clk, .reset, .ce(1'b1), .wake, .cmd_valid,
    .cmd_ready, .cmd, .data_valid, .data_ready, .data_byte, .rng_valid,
    .rng_ready, .rng_byte, .mem_zone, .mem_addr, .mem_index, .mem_rdata,
    .st_start, .st_sel, .st_done, .st_fail, .eng_init, .eng_byte_valid,
    .eng_byte, .eng_ready, .eng_final, .eng_done, .eng_digest, .key_load,
    .mdb_load, .copy_digest, .fail_state, .hash_valid, .link_clk,
    .resp_ready, .resp_valid, .resp);
  sec_periph_model peer_u (.sys_clk, .rng_ready, .rng_valid, .rng_byte,
    .mem_zone, .mem_index, .mem_rdata, .st_start, .st_sel, .fail_mask,
    .st_done, .st_fail, .eng_init, .eng_byte_valid, .eng_byte, .eng_ready,
    .eng_final, .eng_done, .eng_digest, .key_load, .mdb_load, .n_start,
    .n_key, .n_mdb);
  // host side of the link: ready is chosen mid-cycle, and the byte is
  // logged only when that same ready meets valid at the next rising edge
  always @(negedge link_clk) begin
    rdy = ($urandom % 4) != 0;
    if (resp_valid === 1'b1 && rdy) begin
      rq.push_back(resp.data);
      if (resp.last) done = 1;
    end
    resp_ready <= rdy;
  end
  // ----------------------------------------------------------------
  // host tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wait_ok(ref logic s);
    logic ok;
    ok = 0;
    for (int t = 0; t < 300 && !ok; t++) begin
      #9 ok = (s === 1'b1);
      @(negedge sys_clk);
    end
    if (!ok) begin
      num_errors++;
      report_and_stop();
    end
  endtask
  // one command, its message bytes, then the whole answer
  task automatic run(input logic [7:0] op, md, input logic [15:0] p2,
      input int n);
    done = 0;
    rq.delete();
    @(negedge sys_clk);
    cmd_valid = 1;
    cmd = '{op, md, p2};
    wait_ok(cmd_ready);
    cmd_valid = 0;
    for (int i = 0; i < n; i++) begin
      data_valid = 1;
      data_byte = 8'($urandom);
      hs += data_byte;
      wait_ok(data_ready);
    end
    data_valid = 0;
    for (int t = 0; t < 4000 && !done; t++) @(negedge sys_clk);
    if (!done) begin
      num_errors++;
      report_and_stop();
    end
  endtask
  task automatic cmp();
    `CHK(rq.size(), eq.size())
    foreach (eq[i]) `CHK(rq[i], eq[i])
  endtask
  task automatic st1(input logic [7:0] op, md, input logic [15:0] p2,
      input int n, input logic [7:0] code);
    run(op, md, p2, n);
    eq = '{code};
    cmp();
  endtask
  task automatic rd(input logic [1:0] z, input logic l,
      input logic [15:0] p2);
    run(OP_READ, {l, 5'b0, z}, p2, 0);
    eq.delete();
    for (int i = 0; i < (l ? 32 : 4); i++) eq.push_back({z, 1'b0, 5'(i)});
    cmp();
  endtask
  task automatic rnd();
    run(OP_RANDOM, 8'h00, 16'h0000, 0);
    eq.delete();
    repeat (32) eq.push_back(8'(rn++));
    cmp();
  endtask
  task automatic dig(input logic [7:0] md, input int n);
    run(OP_HASH, md, 16'(n), n);
    eq.delete();
    for (int k = 0; k < 32; k++) eq.push_back(hs + 8'(k));
    cmp();
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'ha168ee0e));
    repeat (12) @(negedge sys_clk);
    reset = 0;
    repeat (20) @(negedge sys_clk);
    `CHK(n_start, 0)
    `CHK(fail_state, 6'h00)
    `CHK(hash_valid, 1'b0)
    rnd();
    rnd();
    $display("test random done");
    for (int i = 0; i < 4; i++) rd(2'(i % 2), 1'(i / 2), 16'h0000);
    rd(ZONE_DATA, 1, 16'(ok_slot[$urandom % 5] << 3));
    rd(ZONE_DATA, 0, 16'(5 << 3));
    `CHK(mem_addr, 16'(5 << 3))
    st1(OP_READ, 8'h82, 16'(3 << 3), 0, ERR_DENIED);
    $display("test reads done");
    for (int f = 0; f < 3; f++) begin
      k0 = n_key;
      m0 = n_mdb;
      hs = 0;
      st1(OP_HASH, HASH_START, 0, 0, ST_OK);
      c = 1 + $urandom % 64;
      st1(OP_HASH, HASH_UPDATE, 16'(c), c, ST_OK);
      rnd();
      st1(OP_HASH, HASH_UPDATE, 0, 0, ERR_PARSE);
      st1(OP_HASH, HASH_UPDATE, 64, 64, ST_OK);
      dig(fm[f], f * 32);
      `CHK(copy_digest[255 -: 8], hs)
      `CHK(n_key - k0, int'(f == 0))
      `CHK(n_mdb - m0, int'(f == 1))
    end
    $display("test hash done");
    fail_mask = 6'h04;
    st1(OP_CHECK, CHECK_LEGAL, 0, 0, 8'h04);
    `CHK(fail_state, 6'h04)
    st1(OP_RANDOM, 8'h00, 0, 0, ERR_ENGINE_CHECK_COMMAND);
    st1(OP_READ, 8'h01, 0, 0, ERR_ENGINE_CHECK_COMMAND);
    rd(ZONE_CFG, 0, 16'h0000);
    st1(OP_CHECK, 8'h00, 0, 0, 8'h04);
    fail_mask = 6'h00;
    st1(OP_CHECK, 8'h04, 0, 0, ST_OK);
    `CHK(fail_state, 6'h00)
    rnd();
    st1(OP_CHECK, CHECK_LEGAL, 0, 0, ST_OK);
    $display("test checks done");
    st1(OP_HASH, HASH_START, 0, 0, ST_OK);
    fail_mask = 6'h21;
    st1(OP_CHECK, 8'h21, 0, 0, 8'h21);
    @(negedge sys_clk) wake = 1;
    @(negedge sys_clk) wake = 0;
    repeat (2) @(negedge sys_clk);
    `CHK(fail_state, 6'h00)
    `CHK(hash_valid, 1'b0)
    st1(OP_HASH, HASH_UPDATE, 1, 0, ERR_PARSE);
    $display("test wake done");
    // power-up reset in mid-run must drop both context and failures
    st1(OP_HASH, HASH_START, 0, 0, ST_OK);
    fail_mask = 6'h01;
    st1(OP_CHECK, 8'h01, 0, 0, 8'h01);
    @(negedge sys_clk) reset = 1;
    repeat (16) @(negedge sys_clk);
    reset = 0;
    repeat (4) @(negedge sys_clk);
    `CHK(fail_state, 6'h00)
    `CHK(hash_valid, 1'b0)
    st1(OP_HASH, HASH_UPDATE, 1, 0, ERR_PARSE);
    $display("test reset done");
    report_and_stop();
  end
endmodule
